// File: logic/pos_regs.svh
`ifndef POS_REGS_SVH
`define POS_REGS_SVH
// What this block does
// R1: reserved bits of both registers read as zero; software writes zero there.
// R2: input interrupt enable set means interrupt whenever any input request flag is set.
// R3: mode 00 accepts a request on a high to low transition of that input.
// R4: mode 01 samples on clock divided by 8, accepts after 16 low samples.
// R5: mode 10 samples on clock divided by 16, accepts after 16 low samples.
// R6: mode 11 samples on clock divided by 128, accepts after 16 low samples.
// R7: each input has its own two-bit mode field, input 3 at bits 7-6 downward.
// R8: output short flag bit 15 sets when any compared pair drives both low.
// R9: while output short flag is set, all high-current pins are high impedance.
// R10: output short flag clears only by writing 0 after reading it as 1.
// R11: software writes only zero to flag bits; writing one never sets a flag.
// R12: interrupt enable and all mode bits reset to zero.
// R13: input flags in bits 15-12 set when the selected condition occurs.
// R14: input flag clears only by writing 0 after reading it as 1.
// R15: an accepted request on any input forces all high-current pins high impedance.
// R16: output short interrupt enable gates the interrupt from the output short flag.
// R17: a high sample restarts the low run, so 16 uninterrupted lows are needed.

// register byte offsets
`define POS_IN_CTRL_OFS 8'h00
`define POS_OUT_CTRL_OFS 8'h04
// input control register fields
`define POS_IN_FLAG_LSB 12
`define POS_IN_IRQ_EN_BIT 8
`define POS_IN_MODE_LSB 0
`define POS_IN_RESET 16'h0000
// output control register fields
`define POS_OUT_SHORT_BIT 15
`define POS_OUT_CMP_EN_BIT 9
`define POS_OUT_IRQ_EN_BIT 8
`define POS_OUT_RESET 16'h0000
// sampling divisions and run length
`define POS_DIV_A 8
`define POS_DIV_B 16
`define POS_DIV_C 128
`define POS_SAMPLE_RUN 16
`endif

// File: logic/pos_pkg.sv
package pos_pkg;
	typedef enum logic [1:0] {
		POS_MODE_EDGE = 2'h0,
		POS_MODE_DIV_A = 2'h1,
		POS_MODE_DIV_B = 2'h2,
		POS_MODE_DIV_C = 2'h3
	} pos_mode_t;
	typedef logic [2:0] pos_tick_t;
endpackage

// File: logic/pos_qual_if.sv
interface pos_qual_if;
	import pos_pkg::*;
	pos_mode_t mode;
	pos_tick_t tick;
	logic req_n;
	logic accept;
	modport ctrl(output mode, output tick, output req_n, input accept);
	modport qual(input mode, input tick, input req_n, output accept);
endinterface

// File: logic/pos_qualifier.sv
`include "pos_regs.svh"
module pos_qualifier
	import pos_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// request channel
	pos_qual_if.qual q
);
	localparam int RUN = `POS_SAMPLE_RUN;
	logic prev_reg;
	logic [4:0] run_reg;
	logic accept_reg;
	logic sample_en;

	always_comb begin
		unique case (q.mode)
			POS_MODE_DIV_A: sample_en = q.tick[0];
			POS_MODE_DIV_B: sample_en = q.tick[1];
			POS_MODE_DIV_C: sample_en = q.tick[2];
			POS_MODE_EDGE: sample_en = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= q.req_n;
		end
	end

	// consecutive low samples, restarted by any high sample
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			run_reg <= 5'h00;
		end else if (q.mode == POS_MODE_EDGE) begin
			run_reg <= 5'h00;
		end else if (sample_en) begin
			if (q.req_n) begin
				run_reg <= 5'h00; // R17
			end else if (run_reg != 5'(RUN)) begin
				run_reg <= run_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			accept_reg <= 1'b0;
		end else if (q.mode == POS_MODE_EDGE) begin
			accept_reg <= prev_reg & ~q.req_n; // R3
		end else begin
			accept_reg <= sample_en & ~q.req_n & (run_reg == 5'(RUN - 1)); // R4 R5 R6
		end
	end

	assign q.accept = accept_reg;
endmodule // pos_qualifier

// File: logic/pos_top.sv
`include "pos_regs.svh"
module pos_top
	import pos_pkg::*;
#(
	parameter int NUM_REQ = 4,
	parameter int NUM_PAIRS = 3
) (
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	// register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [15:0] REG_RDATA_OUT,
	// shutdown request inputs, active low
	input wire logic [NUM_REQ-1:0] REQ_N_IN,
	// complementary pair output levels, pair k on bits 2k and 2k+1
	input wire logic [2*NUM_PAIRS-1:0] PAIR_LEVEL_IN,
	// timer output enables of the high-current pins, active low
	input wire logic [2*NUM_PAIRS-1:0] TMR_OE_N_IN,
	// pin drive control and status
	output logic [2*NUM_PAIRS-1:0] HC_OE_N_OUT,
	output logic HIZ_OUT,
	// interrupt
	output logic IRQ_OUT
);
	localparam int DIV_A = `POS_DIV_A;
	localparam int DIV_B = `POS_DIV_B;
	localparam int DIV_C = `POS_DIV_C;
	localparam int RUN = `POS_SAMPLE_RUN;
	localparam int FL = `POS_IN_FLAG_LSB;

	logic [6:0] div_reg;
	pos_tick_t tick;
	logic wr_in_hit;
	logic wr_out_hit;
	logic rd_in_hit;
	logic rd_out_hit;
	logic [NUM_REQ-1:0] flag_reg;
	logic [NUM_REQ-1:0] flag_next;
	logic [NUM_REQ-1:0] armed_reg;
	logic [NUM_REQ-1:0] accept;
	logic [2*NUM_REQ-1:0] mode_reg;
	logic in_irq_en_reg;
	logic short_reg;
	logic short_next;
	logic short_armed_reg;
	logic cmp_en_reg;
	logic out_irq_en_reg;
	logic [NUM_PAIRS-1:0] pair_low;
	logic short_seen;
	logic hiz_reg;
	logic irq_reg;
	logic [15:0] rdata_reg;
	logic [15:0] in_view;
	logic [15:0] out_view;

	// sampling clock divisions from one free-running counter
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			div_reg <= 7'h00;
		end else begin
			div_reg <= div_reg + 7'h01;
		end
	end

	assign tick[0] = (div_reg[2:0] == 3'(DIV_A - 1));
	assign tick[1] = (div_reg[3:0] == 4'(DIV_B - 1));
	assign tick[2] = (div_reg == 7'(DIV_C - 1));

	assign wr_in_hit = REG_WR_IN && (REG_ADDR_IN == `POS_IN_CTRL_OFS);
	assign wr_out_hit = REG_WR_IN && (REG_ADDR_IN == `POS_OUT_CTRL_OFS);
	assign rd_in_hit = REG_RD_IN && (REG_ADDR_IN == `POS_IN_CTRL_OFS);
	assign rd_out_hit = REG_RD_IN && (REG_ADDR_IN == `POS_OUT_CTRL_OFS);

	// one qualifier per request input
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
			pos_qual_if qif();
			assign qif.mode = pos_mode_t'(mode_reg[2*gi+1:2*gi]); // R7
			assign qif.tick = tick;
			assign qif.req_n = REQ_N_IN[gi];
			assign accept[gi] = qif.accept;
			pos_qualifier u_qual (
				.clk_in(REF_CLK_IN),
				.arst_n_in(ARST_N_IN),
				.q(qif.qual)
			);
		end
	endgenerate

	// input control: enable and modes
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			in_irq_en_reg <= 1'b0; // R12
			mode_reg <= 8'h00; // R12
		end else if (wr_in_hit) begin
			in_irq_en_reg <= REG_WDATA_IN[`POS_IN_IRQ_EN_BIT];
			mode_reg <= REG_WDATA_IN[`POS_IN_MODE_LSB +: 2*NUM_REQ]; // R7
		end
	end

	// input flags: clear by write 0 after read 1, set wins
	always_comb begin
		flag_next = flag_reg;
		for (int i = 0; i < NUM_REQ; i++) begin
			if (wr_in_hit && !REG_WDATA_IN[FL+i] && armed_reg[i]) begin
				flag_next[i] = 1'b0; // R14 R11
			end
			if (accept[i]) begin
				flag_next[i] = 1'b1; // R13
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			flag_reg <= 4'h0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// remembers which flags were last read as one
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			armed_reg <= 4'h0;
		end else if (rd_in_hit) begin
			armed_reg <= flag_reg; // R14
		end else if (wr_in_hit) begin
			armed_reg <= 4'h0;
		end
	end

	// output control: compare and interrupt enables
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cmp_en_reg <= 1'b0;
			out_irq_en_reg <= 1'b0;
		end else if (wr_out_hit) begin
			cmp_en_reg <= REG_WDATA_IN[`POS_OUT_CMP_EN_BIT];
			out_irq_en_reg <= REG_WDATA_IN[`POS_OUT_IRQ_EN_BIT];
		end
	end

	// pair comparison
	generate
		for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
			assign pair_low[gi] = ~PAIR_LEVEL_IN[2*gi] & ~PAIR_LEVEL_IN[2*gi+1];
		end
	endgenerate

	assign short_seen = cmp_en_reg && (|pair_low);

	always_comb begin
		short_next = short_reg;
		if (wr_out_hit && !REG_WDATA_IN[`POS_OUT_SHORT_BIT] && short_armed_reg) begin
			short_next = 1'b0; // R10 R11
		end
		if (short_seen) begin
			short_next = 1'b1; // R8
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			short_reg <= 1'b0;
		end else begin
			short_reg <= short_next;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			short_armed_reg <= 1'b0;
		end else if (rd_out_hit) begin
			short_armed_reg <= short_reg; // R10
		end else if (wr_out_hit) begin
			short_armed_reg <= 1'b0;
		end
	end

	// pin release and interrupt
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			hiz_reg <= 1'b0;
		end else begin
			hiz_reg <= (|flag_next) | short_next; // R9 R15
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (in_irq_en_reg & (|flag_reg)) | (out_irq_en_reg & short_reg); // R2 R16
		end
	end

	assign HIZ_OUT = hiz_reg;
	assign HC_OE_N_OUT = TMR_OE_N_IN | {(2*NUM_PAIRS){hiz_reg}}; // R9 R15
	assign IRQ_OUT = irq_reg;

	// read path, reserved bits zero
	always_comb begin
		in_view = 16'h0000;
		in_view[FL +: NUM_REQ] = flag_reg;
		in_view[`POS_IN_IRQ_EN_BIT] = in_irq_en_reg;
		in_view[`POS_IN_MODE_LSB +: 2*NUM_REQ] = mode_reg; // R1
		out_view = 16'h0000;
		out_view[`POS_OUT_SHORT_BIT] = short_reg;
		out_view[`POS_OUT_CMP_EN_BIT] = cmp_en_reg;
		out_view[`POS_OUT_IRQ_EN_BIT] = out_irq_en_reg; // R1
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_reg <= 16'h0000;
		end else if (rd_in_hit) begin
			rdata_reg <= in_view;
		end else if (rd_out_hit) begin
			rdata_reg <= out_view;
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	assign REG_RDATA_OUT = rdata_reg;

	// checks
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	// helper: low run of input 0 on its selected sampling tick
	logic [5:0] chk_run;
	logic chk_tick;
	always_comb begin
		unique case (mode_reg[1:0])
			2'h1: chk_tick = tick[0];
			2'h2: chk_tick = tick[1];
			2'h3: chk_tick = tick[2];
			2'h0: chk_tick = 1'b0;
		endcase
	end
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			chk_run <= 6'h00;
		end else if (mode_reg[1:0] == 2'h0 || (chk_tick && REQ_N_IN[0])) begin
			chk_run <= 6'h00;
		end else if (chk_tick && chk_run != 6'h3f) begin
			chk_run <= chk_run + 6'h01;
		end
	end

	sequence s_read_one;
		rd_in_hit && flag_reg[0];
	endsequence
	sequence s_write_zero;
		wr_in_hit && !REG_WDATA_IN[FL] && !accept[0];
	endsequence
	sequence s_out_read_one;
		rd_out_hit && short_reg;
	endsequence
	sequence s_out_write_zero;
		wr_out_hit && !REG_WDATA_IN[`POS_OUT_SHORT_BIT] && !short_seen;
	endsequence
	sequence s_in_idle;
		!rd_in_hit && !wr_in_hit;
	endsequence
	sequence s_out_idle;
		!rd_out_hit && !wr_out_hit;
	endsequence
	sequence s_flag_irq;
		(|flag_reg) ##1 IRQ_OUT;
	endsequence
	sequence s_short_irq;
		short_reg ##1 IRQ_OUT;
	endsequence

	in_irq_a: assert property ((in_irq_en_reg && |flag_reg) |=> IRQ_OUT) // R2
		else $error("input flag with enable gave no interrupt");
	irq_cause_a: assert property (IRQ_OUT |-> ($past(in_irq_en_reg) && $past(|flag_reg))
		|| ($past(out_irq_en_reg) && $past(short_reg))) // R16
		else $error("interrupt without enabled cause");
	edge_accept_a: assert property ((mode_reg[1:0] == 2'h0 && $fell(REQ_N_IN[0])
		&& $stable(mode_reg)) |=> ##1 flag_reg[0]) // R3
		else $error("falling edge not accepted");
	run_accept_a: assert property ((mode_reg[1:0] != 2'h0 && accept[0] && $stable(mode_reg))
		|-> chk_run == 6'(RUN)) // R4 R5 R6 R17
		else $error("sampled request accepted without full low run");
	short_set_a: assert property (short_seen |=> short_reg) // R8
		else $error("pair short did not set flag");
	short_hiz_a: assert property (short_reg |-> HIZ_OUT) // R9
		else $error("short flag without high impedance");
	short_hold_a: assert property ((short_reg && !wr_out_hit) |=> short_reg) // R10
		else $error("short flag lost without write");
	short_clear_a: assert property (s_out_read_one ##1 s_out_idle ##1 s_out_write_zero // R10
		|=> !short_reg)
		else $error("short flag not cleared after read then write zero");
	flag_hold_a: assert property ((flag_reg[0] && !wr_in_hit) |=> flag_reg[0]) // R14
		else $error("input flag lost without write");
	flag_clear_a: assert property (s_read_one ##1 s_in_idle ##1 s_write_zero // R14
		|=> !flag_reg[0])
		else $error("input flag not cleared after read then write zero");
	accept_hiz_a: assert property (accept[0] |=> HIZ_OUT && flag_reg[0]) // R13 R15
		else $error("accepted request did not release pins");
	reserved_zero_a: assert property ($past(REG_RD_IN) |-> // R1
		(!$past(rd_in_hit) || REG_RDATA_OUT[11:9] == 3'h0)
		&& (!$past(rd_out_hit) || (REG_RDATA_OUT[14:10] == 5'h00
		&& REG_RDATA_OUT[7:0] == 8'h00)))
		else $error("reserved bits read nonzero");
	hiz_cause_a: assert property (HIZ_OUT |-> (|flag_reg) || short_reg) // R9 R15
		else $error("pins released without a flag");
	oe_release_a: assert property (HIZ_OUT |-> &HC_OE_N_OUT) // R9 R15
		else $error("pin driven while released");
	oe_pass_a: assert property (!HIZ_OUT |-> HC_OE_N_OUT == TMR_OE_N_IN) // R9 R15
		else $error("timer enable not passed to pins");
	no_set_in_a: assert property ((wr_in_hit && REG_WDATA_IN[FL] && !flag_reg[0] // R11
		&& !accept[0]) |=> !flag_reg[0])
		else $error("writing one set an input flag");
	no_set_out_a: assert property ((wr_out_hit && REG_WDATA_IN[`POS_OUT_SHORT_BIT] // R11
		&& !short_reg && !short_seen) |=> !short_reg)
		else $error("writing one set the short flag");
	in_keep_a: assert property ((flag_reg[0] && wr_in_hit && !armed_reg[0]) // R14
		|=> flag_reg[0])
		else $error("input flag cleared without prior read");
	out_keep_a: assert property ((short_reg && wr_out_hit && !short_armed_reg) // R10
		|=> short_reg)
		else $error("short flag cleared without prior read");
	mode_write_a: assert property (wr_in_hit // R7
		|=> mode_reg == $past(REG_WDATA_IN[`POS_IN_MODE_LSB +: 2*NUM_REQ]))
		else $error("mode fields not taken from write");
	edge_only_a: assert property ((mode_reg[1:0] == 2'h0 && $stable(mode_reg) && accept[0]) // R3
		|-> $past(REQ_N_IN[0], 2) && !$past(REQ_N_IN[0]))
		else $error("edge mode accepted without a falling edge");
	accept_irq_a: assert property ((|accept && in_irq_en_reg && !wr_in_hit) // R2 R13
		|=> s_flag_irq)
		else $error("accepted request gave no interrupt");
	short_irq_a: assert property ((short_seen && out_irq_en_reg && !wr_out_hit) // R8 R16
		|=> s_short_irq)
		else $error("pair short gave no interrupt");
	irq_mask_a: assert property ((!in_irq_en_reg && !out_irq_en_reg) |=> !IRQ_OUT) // R2 R16
		else $error("interrupt while both enables are off");
	out_irq_a: assert property ((out_irq_en_reg && short_reg) |=> IRQ_OUT) // R16
		else $error("short flag with enable gave no interrupt");
endmodule // pos_top

// File: dv/pos_fault_src.sv
module pos_fault_src (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// lines to pull low
	input wire logic [3:0] low_in,
	// request lines, idle high by pull-up
	output logic [3:0] req_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			req_n_out <= 4'hf;
		end else begin
			req_n_out <= ~low_in;
		end
	end
endmodule // pos_fault_src

// File: dv/port_output_shutdown_ctrl_tb.sv
`include "pos_regs.svh"
`define CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module port_output_shutdown_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic arst_n;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [15:0] rdata;
	logic [3:0] low;
	logic [3:0] req_n;
	logic [5:0] pair;
	logic [5:0] tmr_oe_n;
	logic [5:0] hc_oe_n;
	logic hiz;
	logic irq;
	int n_fail;
	int comparisons;
	pos_fault_src u_pos_fault_src (.clk_in(clk), .arst_n_in(arst_n), .low_in(low),
		.req_n_out(req_n));
	pos_top u_pos_top (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
		.REQ_N_IN(req_n), .PAIR_LEVEL_IN(pair), .TMR_OE_N_IN(tmr_oe_n),
		.HC_OE_N_OUT(hc_oe_n), .HIZ_OUT(hiz), .IRQ_OUT(irq));
	always #25 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask
	task automatic drive(input int i, input logic v, input int n);
		@(posedge clk);
		low[i] <= v;
		cyc(n);
	endtask
	task automatic pins(input logic h, input logic q);
		`CHK(hiz, h)
		`CHK(hc_oe_n, h ? 6'h3f : 6'h15)
		`CHK(irq, q)
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end
	initial begin
		logic [15:0] cfg;
		int p;
		int j;
		clk = 1'b0;
		arst_n = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		low = 4'h0;
		pair = 6'h3f;
		tmr_oe_n = 6'h15;
		n_fail = 0;
		comparisons = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rdc(`POS_IN_CTRL_OFS, `POS_IN_RESET);
		rdc(`POS_OUT_CTRL_OFS, `POS_OUT_RESET);
		wr(8'h08, 16'hffff);
		rdc(8'h08, 16'h0000);
		rdc(`POS_IN_CTRL_OFS, 16'h0000);
		wr(`POS_IN_CTRL_OFS, 16'hffff);
		rdc(`POS_IN_CTRL_OFS, 16'h01ff);
		wr(`POS_OUT_CTRL_OFS, 16'hffff);
		rdc(`POS_OUT_CTRL_OFS, 16'h0300);
		wr(`POS_OUT_CTRL_OFS, 16'h0000);
		// falling edge mode on every line, irq enable alternating
		for (int i = 0; i < 4; i++) begin
			cfg = {7'h00, i[0], 8'h00};
			wr(`POS_IN_CTRL_OFS, cfg);
			drive(i, 1'b1, 8);
			pins(1'b1, i[0]);
			wr(`POS_IN_CTRL_OFS, cfg);
			rdc(`POS_IN_CTRL_OFS, cfg | (16'h1000 << i));
			wr(`POS_IN_CTRL_OFS, cfg);
			rdc(`POS_IN_CTRL_OFS, cfg);
			pins(1'b0, 1'b0);
			drive(i, 1'b0, 3);
		end
		// 15 lows, one high, 15 lows must not accept; 16 lows must
		for (int m = 1; m < 4; m++) begin
			j = m - 1;
			p = (m == 3) ? 128 : 8 * m;
			cfg = 16'(m) << (2 * j);
			wr(`POS_IN_CTRL_OFS, cfg);
			drive(j, 1'b1, 15 * p - 1);
			drive(j, 1'b0, p - 1);
			drive(j, 1'b1, 15 * p - 1);
			drive(j, 1'b0, p + 2);
			rdc(`POS_IN_CTRL_OFS, cfg);
			drive(j, 1'b1, 15 * p - 1);
			rdc(`POS_IN_CTRL_OFS, cfg);
			drive(j, 1'b1, p + 4);
			pins(1'b1, 1'b0);
			drive(j, 1'b0, 2);
			rdc(`POS_IN_CTRL_OFS, cfg | (16'h1000 << j));
			wr(`POS_IN_CTRL_OFS, cfg);
			rdc(`POS_IN_CTRL_OFS, cfg);
		end
		// one-cycle short on each pair
		for (int k = 0; k < 3; k++) begin
			cfg = (k == 1) ? 16'h0200 : 16'h0300;
			wr(`POS_OUT_CTRL_OFS, cfg);
			@(posedge clk);
			pair <= ~(6'h03 << (2 * k));
			@(posedge clk);
			pair <= 6'h3f;
			cyc(3);
			pins(1'b1, k != 1);
			wr(`POS_OUT_CTRL_OFS, cfg);
			rdc(`POS_OUT_CTRL_OFS, cfg | 16'h8000);
			wr(`POS_OUT_CTRL_OFS, cfg);
			rdc(`POS_OUT_CTRL_OFS, cfg);
			pins(1'b0, 1'b0);
		end
		print_verdict();
	end
endmodule // port_output_shutdown_ctrl_tb
